// File: include/scs_pkg.sv
// Constants and types for the system clock source switch.
// Assumes a single pclk domain; oscillator activity arrives as pclk-synchronous ticks.
package scs_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ          = 250;
   localparam int PLL_LOCK_TIME_MS = 2;
   localparam int PLL_LOCK_CYCLES  = PLL_LOCK_TIME_MS * 1000 * CLK_MHZ;
   localparam int OST_COUNT        = 1024;
   localparam logic [1:0] OLD_TICKS = 2'h2;
   localparam logic [1:0] NEW_TICKS = 2'h3;

   // ==========================================================
   // Register map
   localparam logic [7:0] OSC_CTRL_OFF = 8'h00;
   localparam logic [7:0] LF_SRC_OFF   = 8'h04;
   localparam logic [7:0] STATUS_OFF   = 8'h08;

   localparam int IDLE_BIT = 7;
   localparam int FREQ_LSB = 4;
   localparam int PRIMARY_STARTED_FLAG_BIT = 3;
   localparam int INTERNAL_STABLE_FLAG_BIT = 2;
   localparam int SCS_LSB  = 0;
   localparam int LF_BIT   = 0;

   localparam logic [1:0] SCS_RESET = 2'h0;
   localparam logic [1:0] SCS_PRI   = 2'h0;
   localparam logic [1:0] SCS_SEC   = 2'h1;
   localparam logic [2:0] FREQ_RESET = 3'h4;
   localparam logic [2:0] FREQ_31K   = 3'h0;

   // ==========================================================
   // Types
   localparam int SRC_N = 4;
   typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_TUNABLE_INTERNAL_OSC, SRC_LOW_POWER_INTERNAL_RC} scs_src_type;
   typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} scs_sw_state_type;

endpackage

// File: include/scs_sw_if.sv
// Link between the clock controller and the glitch-free source multiplexer.
// Assumes both ends share pclk.
`timescale 1ns/1ps
interface scs_sw_if
   import scs_pkg::*;
   ();
   logic [SRC_N-1:0] src_tick;
   logic [SRC_N-1:0] src_ready;
   scs_src_type      target;
   scs_src_type      active;
   logic             switching;
   logic             clk_tick;

   modport ctrl (output src_tick, output src_ready, output target,
                 input active, input switching, input clk_tick);
   modport mux  (input src_tick, input src_ready, input target,
                 output active, output switching, output clk_tick);
endinterface

// File: design/scs_glitch_mux.sv
// Glitch-free handover between clock sources carried as ticks.
// Assumes src_ready is level-stable and src_tick is one pclk cycle per source edge.
`timescale 1ns/1ps
module scs_glitch_mux
   import scs_pkg::*;
   (
   input wire logic pclk,
   input wire logic presetn,
   scs_sw_if.mux    sw
   );

   scs_sw_state_type state;
   scs_src_type      act;
   scs_src_type      tgt;
   logic [1:0]       cnt;

   // ==========================================================
   // Handover sequence
   // Starts on the RC, enabled from reset, so the first handover never waits on a dead clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SW_RUN;
         act   <= SRC_LOW_POWER_INTERNAL_RC;
         tgt   <= SRC_LOW_POWER_INTERNAL_RC;
         cnt   <= 2'h0;
      end else begin
         case (state)
            SW_RUN: begin
               if (sw.target != act && sw.src_ready[sw.target]) begin
                  tgt   <= sw.target;
                  cnt   <= 2'h0;
                  state <= SW_OLD;
               end
            end
            SW_OLD: begin
               if (sw.src_tick[act]) begin
                  if (cnt == OLD_TICKS - 2'h1) begin
                     cnt   <= 2'h0;
                     state <= SW_NEW;
                  end else begin
                     cnt <= cnt + 2'h1;
                  end
               end
            end
            SW_NEW: begin
               if (sw.src_tick[tgt]) begin
                  if (cnt == NEW_TICKS - 2'h1) begin
                     act   <= tgt;
                     state <= SW_RUN;
                  end else begin
                     cnt <= cnt + 2'h1;
                  end
               end
            end
            default: begin
               state <= SW_RUN;
            end
         endcase
      end
   end

   assign sw.active    = act;
   assign sw.switching = (state != SW_RUN);
   assign sw.clk_tick  = (state == SW_RUN) && sw.src_tick[act];

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PAUSE_DURING_SWITCH: assert property (
      (state != SW_RUN) |-> !sw.clk_tick)
      else $error("clock tick leaked during source switch");
   AST_HOLD_UNTIL_READY: assert property (
      (state == SW_RUN && !sw.src_ready[sw.target]) |=> (state == SW_RUN && act == $past(act)))
      else $error("switch began toward a source that was not ready");

endmodule

// File: design/scs_clock_switch.sv
// System clock source switch with APB register access.
// Assumes all oscillator ticks and status inputs are synchronous to pclk.
`timescale 1ns/1ps
module scs_clock_switch
   import scs_pkg::*;
   #(
   parameter int         PLL_CYCLES   = PLL_LOCK_CYCLES,
   parameter logic [3:0] CRYSTAL_LAST = 4'h2,
   parameter logic [3:0] PLL_MODE     = 4'h6
   )
   (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pri_tick,
   input  wire logic        sec_tick,
   input  wire logic        tunable_internal_osc_tick,
   input  wire logic        low_power_internal_rc_tick,
   input  wire logic        tunable_internal_osc_stable,
   input  wire logic        secondary_osc_enable,
   input  wire logic [3:0]  primary_mode_config,
   input  wire logic        two_speed_startup_config,
   input  wire logic        wdt_enable,
   input  wire logic        sleep_req,
   input  wire logic        wake_req,
   output logic             sys_clk_tick,
   output logic             cpu_clk_tick,
   output logic             periph_clk_tick,
   output logic             wdt_clk_tick,
   output logic             pri_osc_en,
   output logic             tunable_internal_osc_en,
   output logic             low_power_internal_rc_en,
   output logic             sec_osc_en,
   output logic             secondary_running_flag,
   output logic             sleep_mode,
   output logic             idle_mode
   );

   // ==========================================================
   // Declarations
   scs_sw_if sw_bus ();

   logic        idle_on_sleep;
   logic [2:0]  internal_freq_select;
   logic [1:0]  system_clock_select;
   logic        low_freq_source_select;
   logic        primary_started_flag;
   logic        internal_stable_flag;
   logic        booted;
   logic        two_speed;
   logic [7:0]  ps_cnt;
   logic [7:0]  ps_mask;
   logic [2:0]  freq_eff;
   logic        int_out_tick;
   scs_src_type int_src;
   scs_src_type next_target;
   logic [10:0] ost_cnt;
   logic        ost_done;
   logic [19:0] pll_cnt;
   logic        pri_ready;
   logic        crystal;
   logic        is_pll;
   logic        wr;
   logic [31:0] next_rdata;
   logic        next_err;
   logic        next_sys;
   logic        next_pri_en;
   logic        next_tunable_internal_osc_en;

   scs_glitch_mux i_scs_glitch_mux (
      .pclk    (pclk),
      .presetn (presetn),
      .sw      (sw_bus.mux)
   );

   assign crystal = (primary_mode_config <= CRYSTAL_LAST) || is_pll;
   assign is_pll  = (primary_mode_config == PLL_MODE);
   assign wr      = psel && penable && pready && pwrite;

   // ==========================================================
   // Control register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_on_sleep          <= 1'b0;
         internal_freq_select   <= FREQ_RESET;
         system_clock_select    <= SCS_RESET;
         low_freq_source_select <= 1'b0;
      end else if (wr) begin
         if (paddr == OSC_CTRL_OFF) begin
            idle_on_sleep        <= pwdata[IDLE_BIT];
            internal_freq_select <= pwdata[FREQ_LSB +: 3];
            // Secondary select is dropped while its oscillator is disabled
            if (!(pwdata[SCS_LSB +: 2] == SCS_SEC && !secondary_osc_enable)) begin
               system_clock_select <= pwdata[SCS_LSB +: 2];
            end
         end else if (paddr == LF_SRC_OFF) begin
            low_freq_source_select <= pwdata[LF_BIT];
         end
      end
   end

   // ==========================================================
   // Two-speed start-up
   // Configuration is caught one edge after release, never in the async branch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         booted    <= 1'b0;
         two_speed <= 1'b0;
      end else if (!booted) begin
         booted    <= 1'b1;
         two_speed <= two_speed_startup_config;
      end else if (wake_req && sleep_mode && two_speed_startup_config) begin
         two_speed <= 1'b1;
      end else if (pri_ready || system_clock_select != SCS_PRI) begin
         two_speed <= 1'b0;
      end
   end

   // ==========================================================
   // Internal block postscaler
   always_comb begin
      freq_eff = internal_freq_select;
      if (two_speed && system_clock_select == SCS_PRI) begin
         freq_eff = FREQ_RESET;
      end
      case (freq_eff)
         3'h7:    ps_mask = 8'h00;
         3'h6:    ps_mask = 8'h01;
         3'h5:    ps_mask = 8'h03;
         3'h4:    ps_mask = 8'h07;
         3'h3:    ps_mask = 8'h0F;
         3'h2:    ps_mask = 8'h1F;
         3'h1:    ps_mask = 8'h3F;
         default: ps_mask = 8'hFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_cnt <= 8'h00;
      end else if (tunable_internal_osc_tick) begin
         ps_cnt <= ps_cnt + 8'h01;
      end
   end

   // Mask is applied live, so a new setting takes effect on the next tick
   assign int_out_tick = tunable_internal_osc_tick && ((ps_cnt & ps_mask) == ps_mask);

   always_comb begin
      int_src = SRC_TUNABLE_INTERNAL_OSC;
      if (freq_eff == FREQ_31K && !low_freq_source_select) begin
         int_src = SRC_LOW_POWER_INTERNAL_RC;
      end
      if (system_clock_select[1]) begin
         next_target = int_src;
      end else if (system_clock_select == SCS_SEC) begin
         next_target = SRC_SEC;
      end else if (two_speed) begin
         next_target = int_src;
      end else begin
         next_target = SRC_PRI;
      end
   end

   // ==========================================================
   // Primary start-up and PLL lock timers
   // Any stop of the primary oscillator restarts the whole start-up count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ost_cnt   <= 11'h000;
         ost_done  <= 1'b0;
         pll_cnt   <= 20'h00000;
         pri_ready <= 1'b0;
      end else if (!pri_osc_en) begin
         ost_cnt   <= 11'h000;
         ost_done  <= 1'b0;
         pll_cnt   <= 20'h00000;
         pri_ready <= 1'b0;
      end else if (!ost_done) begin
         if (!crystal) begin
            ost_done <= 1'b1;
         end else if (pri_tick) begin
            if (ost_cnt == 11'(OST_COUNT - 1)) begin
               ost_done <= 1'b1;
            end else begin
               ost_cnt <= ost_cnt + 11'h001;
            end
         end
      end else if (!pri_ready) begin
         if (!is_pll || pll_cnt == 20'(PLL_CYCLES - 1)) begin
            pri_ready <= 1'b1;
         end else begin
            pll_cnt <= pll_cnt + 20'h00001;
         end
      end
   end

   // ==========================================================
   // Multiplexer hookup
   assign sw_bus.src_tick  = {low_power_internal_rc_tick, int_out_tick, sec_tick, pri_tick};
   assign sw_bus.src_ready = {1'b1, tunable_internal_osc_stable, secondary_osc_enable, pri_ready};
   assign sw_bus.target    = next_target;

   // ==========================================================
   // Power-managed mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_mode <= 1'b0;
         idle_mode  <= 1'b0;
      end else if (wake_req) begin
         sleep_mode <= 1'b0;
         idle_mode  <= 1'b0;
      end else if (sleep_req && !sleep_mode && !idle_mode) begin
         idle_mode  <= idle_on_sleep;
         sleep_mode <= !idle_on_sleep;
      end
   end

   // ==========================================================
   // Oscillator enables and clock outputs
   always_comb begin
      next_sys    = sw_bus.clk_tick && !sleep_mode;
      next_pri_en = !sleep_mode &&
                    (system_clock_select == SCS_PRI || sw_bus.active == SRC_PRI);
      next_tunable_internal_osc_en = !sleep_mode && ((int_src == SRC_TUNABLE_INTERNAL_OSC && next_target == SRC_TUNABLE_INTERNAL_OSC) ||
                       sw_bus.active == SRC_TUNABLE_INTERNAL_OSC);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_clk_tick    <= 1'b0;
         cpu_clk_tick    <= 1'b0;
         periph_clk_tick <= 1'b0;
         wdt_clk_tick    <= 1'b0;
         pri_osc_en      <= 1'b0;
         tunable_internal_osc_en       <= 1'b0;
         low_power_internal_rc_en        <= 1'b1;
         sec_osc_en      <= 1'b0;
      end else begin
         sys_clk_tick    <= next_sys;
         cpu_clk_tick    <= next_sys && !idle_mode;
         periph_clk_tick <= next_sys;
         wdt_clk_tick    <= low_power_internal_rc_tick;
         pri_osc_en      <= next_pri_en;
         tunable_internal_osc_en       <= next_tunable_internal_osc_en;
         low_power_internal_rc_en        <= !sleep_mode || wdt_enable;
         sec_osc_en      <= secondary_osc_enable;
      end
   end

   // ==========================================================
   // Status flags
   // Flags are gated by the active source, so they can never overlap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_started_flag   <= 1'b0;
         internal_stable_flag   <= 1'b0;
         secondary_running_flag <= 1'b0;
      end else begin
         primary_started_flag <= pri_ready && sw_bus.active == SRC_PRI &&
                                 !sw_bus.switching;
         internal_stable_flag <= tunable_internal_osc_stable && sw_bus.active == SRC_TUNABLE_INTERNAL_OSC &&
                                 !sw_bus.switching;
         secondary_running_flag <= sw_bus.active == SRC_SEC && !sw_bus.switching;
      end
   end

   // ==========================================================
   // APB slave
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (paddr == OSC_CTRL_OFF) begin
         next_rdata[IDLE_BIT]      = idle_on_sleep;
         next_rdata[FREQ_LSB +: 3] = internal_freq_select;
         next_rdata[PRIMARY_STARTED_FLAG_BIT]      = primary_started_flag;
         next_rdata[INTERNAL_STABLE_FLAG_BIT]      = internal_stable_flag;
         next_rdata[SCS_LSB +: 2]  = system_clock_select;
      end else if (paddr == LF_SRC_OFF) begin
         next_rdata[LF_BIT] = low_freq_source_select;
      end else if (paddr == STATUS_OFF) begin
         next_rdata[5:0] = {sw_bus.active, sw_bus.switching, idle_mode, sleep_mode,
                            secondary_running_flag};
      end else begin
         next_err = 1'b1;
      end
   end

   // One wait-free access cycle: data is captured in setup and shown with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= next_err;
         prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_RESET_FIELDS: assert property (
      !booted |-> (system_clock_select == SCS_RESET && internal_freq_select == FREQ_RESET))
      else $error("select fields not at reset values after release");
   AST_SEC_IGNORED: assert property (
      (wr && paddr == OSC_CTRL_OFF && pwdata[1:0] == SCS_SEC && !secondary_osc_enable)
      |=> system_clock_select == $past(system_clock_select))
      else $error("secondary select accepted while oscillator disabled");
   AST_FLAGS_EXCLUSIVE: assert property (
      $onehot0({primary_started_flag, internal_stable_flag, secondary_running_flag}))
      else $error("more than one source flag set");
   AST_PRIMARY_STARTED_FLAG_AFTER_TIMER: assert property (
      primary_started_flag |-> $past(pri_ready) && $past(ost_done))
      else $error("primary started flag set before timers expired");
   AST_SLEEP_STOPS: assert property (
      (sleep_mode && $past(sleep_mode)) |-> (!sys_clk_tick && !pri_osc_en && !tunable_internal_osc_en))
      else $error("clock source still running in sleep");
   AST_PRI_OFF: assert property (
      (system_clock_select != SCS_PRI && sw_bus.active != SRC_PRI) |=> !pri_osc_en)
      else $error("primary oscillator left running outside primary mode");
   AST_TUNABLE_INTERNAL_OSC_OFF_ON_RC: assert property (
      (sw_bus.active == SRC_LOW_POWER_INTERNAL_RC && next_target == SRC_LOW_POWER_INTERNAL_RC) |=> !tunable_internal_osc_en)
      else $error("tunable oscillator on while device runs from RC");
   AST_WDT_FROM_RC: assert property (
      wdt_clk_tick == $past(low_power_internal_rc_tick))
      else $error("watchdog clock not taken from RC");
   AST_IDLE_ENTRY: assert property (
      (sleep_req && !wake_req && !sleep_mode && !idle_mode && idle_on_sleep)
      |=> (idle_mode && !sleep_mode))
      else $error("sleep request with idle bit did not enter idle");
   AST_OST_COUNT: assert property (
      ($rose(ost_done) && crystal && $past(pri_osc_en)) |-> $past(ost_cnt) == 11'(OST_COUNT - 1))
      else $error("start-up timer ended at wrong count");

   COV_SWITCH_DONE: cover property (sw_bus.switching ##1 !sw_bus.switching);
   COV_SLEEP: cover property (!sleep_mode ##1 sleep_mode);
   COV_IDLE: cover property (!idle_mode ##1 idle_mode);
   COV_TWO_SPEED_END: cover property (two_speed ##1 !two_speed);

endmodule

// File: dv/scs_osc_model.sv
// ==========
// Oscillator sources model: one tick stream for each clock source.
// Assumes the enables come from the switch and are synchronous to pclk.
`timescale 1ns/1ps
module scs_osc_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pri_osc_en,
   input  wire logic sec_osc_en,
   input  wire logic tunable_internal_osc_en,
   input  wire logic low_power_internal_rc_en,
   output logic      pri_tick,
   output logic      sec_tick,
   output logic      tunable_internal_osc_tick,
   output logic      low_power_internal_rc_tick,
   output logic      tunable_internal_osc_stable
);
   logic [7:0] cnt;
   logic [3:0] warm;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
   // A stopped oscillator gives no ticks at all
   assign pri_tick    = pri_osc_en && cnt[0];
   assign sec_tick    = sec_osc_en && (cnt[2:0] == 3'h5);
   assign tunable_internal_osc_tick = tunable_internal_osc_en && (cnt[1:0] == 2'h1);
   assign low_power_internal_rc_tick  = low_power_internal_rc_en && (cnt[2:0] == 3'h3);
   // Stable only after some ticks, and lost as soon as it is switched off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm <= 4'h0;
      end else if (!tunable_internal_osc_en) begin
         warm <= 4'h0;
      end else if (tunable_internal_osc_tick && warm != 4'hF) begin
         warm <= warm + 4'h1;
      end
   end
   assign tunable_internal_osc_stable = tunable_internal_osc_en && (warm > 4'h7);
endmodule

// File: dv/testbench.sv
// ==========
// Testbench for the clock source switch, driven over APB.
// Assumes the oscillator model sits on the far side of the switch.
`timescale 1ns/1ps
module testbench;
   import scs_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pri_tick, sec_tick, tunable_internal_osc_tick, low_power_internal_rc_tick, tunable_internal_osc_stable;
   logic        sec_en_in, two_speed, wdt_enable, sleep_req, wake_req;
   logic [3:0]  pmode;
   logic        sys_clk_tick, cpu_clk_tick, periph_clk_tick, wdt_clk_tick;
   logic        pri_osc_en, tunable_internal_osc_en, low_power_internal_rc_en, sec_osc_en, sec_flag, sleep_mode, idle_mode;
   logic        er;
   int          errors, checks, n;
   scs_clock_switch #(.PLL_CYCLES(20)) i_scs_clock_switch (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pri_tick(pri_tick), .sec_tick(sec_tick), .tunable_internal_osc_tick(tunable_internal_osc_tick),
      .low_power_internal_rc_tick(low_power_internal_rc_tick), .tunable_internal_osc_stable(tunable_internal_osc_stable),
      .secondary_osc_enable(sec_en_in), .primary_mode_config(pmode),
      .two_speed_startup_config(two_speed), .wdt_enable(wdt_enable),
      .sleep_req(sleep_req), .wake_req(wake_req), .sys_clk_tick(sys_clk_tick),
      .cpu_clk_tick(cpu_clk_tick), .periph_clk_tick(periph_clk_tick),
      .wdt_clk_tick(wdt_clk_tick), .pri_osc_en(pri_osc_en), .tunable_internal_osc_en(tunable_internal_osc_en),
      .low_power_internal_rc_en(low_power_internal_rc_en), .sec_osc_en(sec_osc_en), .secondary_running_flag(sec_flag),
      .sleep_mode(sleep_mode), .idle_mode(idle_mode));
   scs_osc_model i_scs_osc_model (
      .pclk(pclk), .presetn(presetn), .pri_osc_en(pri_osc_en), .sec_osc_en(sec_osc_en),
      .tunable_internal_osc_en(tunable_internal_osc_en), .low_power_internal_rc_en(low_power_internal_rc_en), .pri_tick(pri_tick), .sec_tick(sec_tick),
      .tunable_internal_osc_tick(tunable_internal_osc_tick), .low_power_internal_rc_tick(low_power_internal_rc_tick), .tunable_internal_osc_stable(tunable_internal_osc_stable));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ==========
   // Shared tasks
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Poll status until the active source field matches
   task automatic wait_src(input logic [1:0] s);
      n = 0;
      do begin apb(1'b0, STATUS_OFF, 32'h0); n++; end while (rd[5:4] !== s && n < 2000);
      chk("active source", rd[5:4], s);
   endtask
   task automatic stop_test();
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      stop_test();
   end
   // ==========
   // Tests
   initial begin
      errors = 0; checks = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; sec_en_in = 1'b0; two_speed = 1'b0; wdt_enable = 1'b1;
      sleep_req = 1'b0; wake_req = 1'b0; pmode = 4'h1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("osc_ctrl reset", rd & 32'hF3, 32'h40);
      apb(1'b0, LF_SRC_OFF, 32'h0);
      chk("lf reset", rd, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped err", {er, rd[30:0]}, 32'h80000000);
      wait_src(2'h0);
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("primary started", rd[3:0], 4'h8);
      apb(1'b1, OSC_CTRL_OFF, 32'h41);
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("sec refused", rd[1:0], 2'h0);
      sec_en_in <= 1'b1;
      repeat (40) @(posedge pclk);
      chk("sec osc en", sec_osc_en, 1'b1);
      apb(1'b1, OSC_CTRL_OFF, 32'h41);
      wait_src(2'h1);
      chk("sec active", {sec_flag, rd[5:4]}, 3'h5);
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("sec flags", rd[3:0], 4'h1);
      apb(1'b1, OSC_CTRL_OFF, 32'h72);
      wait_src(2'h2);
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("int stable", {sec_flag, pri_osc_en, rd[3:0]}, 6'h06);
      apb(1'b1, OSC_CTRL_OFF, 32'h03);
      wait_src(2'h3);
      chk("rc direct", {tunable_internal_osc_en, low_power_internal_rc_en}, 2'h1);
      apb(1'b1, LF_SRC_OFF, 32'h1);
      wait_src(2'h2);
      chk("lf tunable", tunable_internal_osc_en, 1'b1);
      @(posedge pclk) sleep_req <= 1'b1;
      @(posedge pclk) sleep_req <= 1'b0;
      repeat (3) @(posedge pclk);
      n = 0;
      repeat (64) @(posedge pclk) n += 64 * (sys_clk_tick !== 1'b0) + (wdt_clk_tick === 1'b1);
      chk("sleep", {sleep_mode, idle_mode, pri_osc_en, tunable_internal_osc_en, low_power_internal_rc_en}, 5'h11);
      chk("sleep ticks", n / 64, 0);
      chk("wdt ticks", n % 64 > 0, 1'b1);
      @(posedge pclk) wake_req <= 1'b1;
      @(posedge pclk) wake_req <= 1'b0;
      apb(1'b1, OSC_CTRL_OFF, 32'hF2);
      @(posedge pclk) sleep_req <= 1'b1;
      @(posedge pclk) sleep_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("idle", {sleep_mode, idle_mode}, 2'h1);
      n = 0;
      repeat (32) @(posedge pclk) n += 64 * (cpu_clk_tick !== 1'b0) + (periph_clk_tick === 1'b1);
      chk("idle cpu ticks", n / 64, 0);
      chk("idle periph ticks", n % 64 > 0, 1'b1);
      // Second start: two-speed on the internal block while the PLL primary warms up
      @(posedge pclk) presetn <= 1'b0;
      two_speed <= 1'b1;
      pmode <= 4'h6;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("pll pending", rd[3:0], 4'h0);
      wait_src(2'h2);
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("two speed", {tunable_internal_osc_en, pri_osc_en, rd[7:0]}, 10'h344);
      wait_src(2'h0);
      apb(1'b0, OSC_CTRL_OFF, 32'h0);
      chk("pll started", rd[7:0], 8'h48);
      stop_test();
   end
endmodule
